// ==== tb_top.sv ====
// Self-checking bench for the watchdog and configuration word block
`timescale 1ns/1ns
module tb_top;
  localparam int WBT = 8;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic wdtOscTick = 1'b0;
  logic externalResetPin_n = 1'b1;
  logic [11:0] cfgWord = 12'hfff;
  logic chipReset, coreClockRun, watchdogEnableFuse, prescalerToTimer0;
  logic irq, er;
  logic tickEn = 1'b0;
  logic [1:0] oscillatorSelect;
  logic [1:0] tickDiv = 2'h0;
  logic [8:0] codeProtect;
  int n_fail = 0;
  int checked = 0;
  int n;
  always #2 mclk = ~mclk;
  // RC oscillator stand-in: one tick every fourth core clock
  always @(posedge mclk) begin
    tickDiv <= tickDiv + 2'h1;
    wdtOscTick <= tickEn && tickDiv == 2'h3;
  end
  wdc_core_model core (.mclk(mclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  wdc_watchdog #(.RESET_DELAY_CYCLES(20), .WDT_BASE_TICKS(WBT),
    .MULTI_PROTECT(1'b1)) DUT (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdtOscTick(wdtOscTick), .externalResetPin_n(externalResetPin_n),
    .configWordIn(cfgWord), .chipReset(chipReset),
    .coreClockRun(coreClockRun), .oscillatorSelect(oscillatorSelect),
    .watchdogEnableFuse(watchdogEnableFuse), .codeProtect(codeProtect),
    .prescalerToTimer0(prescalerToTimer0), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_sim;
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, rd, er);
  endtask
  task automatic rdx(input logic [7:0] a);
    core.xfer(1'b0, a, 32'h0, rd, er);
  endtask
  task automatic wait_run;
    for (int i = 0; i < 400 && coreClockRun !== 1'b1; i++) @(posedge mclk);
    chk("running", coreClockRun, 1);
  endtask
  task automatic por(input logic [11:0] c);
    sys_rst <= 1'b1;
    cfgWord <= c;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_run;
  endtask
  // Ticks from a clear (or sleep) until the time-out reset shows
  task automatic time_out(input logic [31:0] cmd);
    wr(wdc_pkg::OFS_CMD, cmd);
    n = 0;
    tickEn <= 1'b1;
    for (int i = 0; i < 20000 && chipReset !== 1'b1; i++) begin
      @(posedge mclk);
      if (wdtOscTick) n++;
    end
    tickEn <= 1'b0;
    wait_run;
  endtask
  function automatic int exp_ticks(input logic [5:0] opt);
    return opt[3] ? (WBT << opt[2:0]) : WBT;
  endfunction
  initial begin
    logic [11:0] c;
    logic [5:0] opt;
    void'($urandom(51));
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_run;
    for (int k = 0; k < 4; k++) begin
      c = {9'($urandom()), 1'b1, 2'(k)};
      por(c);
      rdx(wdc_pkg::OFS_CONFIG);
      chk("config", rd, {20'h0, c});
      chk("osc", oscillatorSelect, k);
    end
    rdx(wdc_pkg::OFS_OPTION);
    chk("option", rd, 32'h3f);
    rdx(wdc_pkg::OFS_STATUS);
    chk("status", rd, 32'h19);
    rdx(8'h1c);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    wr(wdc_pkg::OFS_CONFIG, 32'h0);
    cfgWord <= ~c;
    rdx(wdc_pkg::OFS_CONFIG);
    chk("config ro", rd, {20'h0, c});
    cfgWord <= c;
    wr(wdc_pkg::OFS_IRQ_MASK, 32'h1);
    for (int k = 0; k < 3; k++) begin
      opt = {3'h1, 3'($urandom_range(0, 3))};
      if (k == 2) begin
        opt = 6'h05;
        core.to_timer0(3'h5);
      end else begin
        wr(wdc_pkg::OFS_OPTION, {26'h0, opt});
      end
      time_out(32'h1);
      chk("ticks", n >= exp_ticks(opt) - 1 && n <= exp_ticks(opt), 1);
      rdx(wdc_pkg::OFS_STATUS);
      chk("timeout flag", rd[4], 0);
      rdx(wdc_pkg::OFS_OPTION);
      chk("option after", rd, 32'h3f);
      chk("irq", irq, 1);
      wr(wdc_pkg::OFS_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge mclk);
      chk("irq clear", irq, 0);
    end
    wr(wdc_pkg::OFS_OPTION, 32'h08);
    tickEn <= 1'b1;
    repeat (12) begin
      wr(wdc_pkg::OFS_CMD, 32'h1);
      repeat (10) @(posedge mclk);
    end
    tickEn <= 1'b0;
    rdx(wdc_pkg::OFS_STATUS);
    chk("cleared", rd[4:0], 5'h19);
    wr(wdc_pkg::OFS_IRQ_MASK, 32'h0);
    time_out(32'h2);
    rdx(wdc_pkg::OFS_STATUS);
    chk("wake flags", rd[4:3], 2'h0);
    chk("masked", irq, 0);
    wr(wdc_pkg::OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge mclk);
    chk("wake irq", irq, 1);
    wr(wdc_pkg::OFS_IRQ_STATUS, 32'h3);
    por(12'hffb);
    wr(wdc_pkg::OFS_OPTION, 32'h08);
    wr(wdc_pkg::OFS_CMD, 32'h2);
    tickEn <= 1'b1;
    repeat (300) @(posedge mclk);
    chk("still asleep", coreClockRun, 0);
    rdx(wdc_pkg::OFS_COUNT);
    chk("count off", rd, 0);
    externalResetPin_n <= 1'b0;
    repeat (2) @(posedge mclk);
    externalResetPin_n <= 1'b1;
    tickEn <= 1'b0;
    wait_run;
    rdx(wdc_pkg::OFS_STATUS);
    chk("pin wake flags", rd[4:3], 2'h2);
    end_sim;
  end
  initial begin
    #200000;
    n_fail++;
    end_sim;
  end
endmodule

// ==== wdc_core_model.sv ====
// Core-side model that issues commands to the block over APB
`timescale 1ns/1ns
module wdc_core_model (
  input wire logic mclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released data must not look like a held value
    pwdata <= ~d;
  endtask
  // Clear first, so a half-full postscaler cannot fire on the move
  task automatic to_timer0(input logic [2:0] ratio);
    logic [31:0] r;
    logic e;
    xfer(1'b1, wdc_pkg::OFS_CMD, 32'h1, r, e);
    xfer(1'b1, wdc_pkg::OFS_OPTION, {29'h0, ratio}, r, e);
  endtask
endmodule

// ==== wdc_pkg.sv ====
// Package of constants for the watchdog and configuration word block
package wdc_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_OPTION = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;

  // ----------------------------------------------------------------------
  // Option register layout
  // ----------------------------------------------------------------------
  localparam int OPTION_W = 6;
  localparam logic [5:0] OPTION_RESET = 6'h3f;
  localparam int OPT_PRESCALER_ASSIGN = 3;
  localparam int OPT_RATIO_LSB = 0;
  localparam int RATIO_W = 3;

  // ----------------------------------------------------------------------
  // Command register bits
  // ----------------------------------------------------------------------
  localparam int CMD_WATCHDOG_CLEAR = 0;
  localparam int CMD_SLEEP = 1;

  // ----------------------------------------------------------------------
  // Status register bits
  // ----------------------------------------------------------------------
  localparam int ST_RUNNING = 0;
  localparam int ST_ASLEEP = 1;
  localparam int ST_IN_RESET = 2;
  localparam int ST_POWERDOWN_N = 3;
  localparam int ST_TIMEOUT_N = 4;

  // ----------------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------------
  localparam int CFG_W = 12;
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_OSC_W = 2;
  localparam int CFG_WDT_ENABLE = 2;
  localparam int CFG_PROTECT_LSB = 3;
  localparam logic [11:0] CFG_SINGLE_MASK = 12'h00f;
  localparam logic [11:0] CFG_MULTI_MASK = 12'hfff;

  typedef enum logic [1:0] {
    OSC_LOW_POWER_CRYSTAL = 2'h0,
    OSC_STANDARD_CRYSTAL = 2'h1,
    OSC_HIGH_SPEED_CRYSTAL = 2'h2,
    OSC_RESISTOR_CAPACITOR = 2'h3
  } wdc_osc_e;

  // ----------------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WAKE = 1;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RESET_DELAY_MS = 18;
  localparam int RESET_DELAY_CYCLES =
    (RESET_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int WDT_TIMEOUT_MS = 18;
  localparam int WDT_OSC_PERIOD_NS = 1000;
  localparam int WDT_BASE_TICKS =
    (WDT_TIMEOUT_MS * 1000000) / WDT_OSC_PERIOD_NS;
  localparam int COUNT_W = 24;

endpackage

// ==== wdc_watchdog.sv ====
// Watchdog, reset-delay timer, sleep control and configuration word
//
// Behaviour
// - Watchdog stops only through the enable fuse
// - Watchdog counts on its own oscillator, even asleep
// - Time-out forces device reset, also wakes from sleep
// - Time-out reset clears the active-low time-out flag
// - Reset-delay timer holds reset for 18 ms
// - Only external reset or time-out ends sleep
// - Config bits 1:0 select the oscillator type
// - Config bit 2 enables the watchdog
// - Multi variant: bits 11:3 are code protection
// - Single variant: bit 3 protects, 11:4 read zero
// - Prescaler serves Timer0 or watchdog, never both
// - Watchdog clear resets counter and assigned prescaler
// - Time-out 18 ms, prescaler extends up to 1:128
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
module wdc_watchdog #(
  parameter int RESET_DELAY_CYCLES = wdc_pkg::RESET_DELAY_CYCLES,
  parameter int WDT_BASE_TICKS = wdc_pkg::WDT_BASE_TICKS,
  parameter bit MULTI_PROTECT = 1'b1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wdtOscTick,
  input wire logic externalResetPin_n,
  input wire logic [wdc_pkg::CFG_W-1:0] configWordIn,
  output logic chipReset,
  output logic coreClockRun,
  output logic [wdc_pkg::CFG_OSC_W-1:0] oscillatorSelect,
  output logic watchdogEnableFuse,
  output logic [8:0] codeProtect,
  output logic prescalerToTimer0,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------------
  localparam logic [31:0] DRT_LAST = 32'(RESET_DELAY_CYCLES - 1);
  localparam logic [11:0] CFG_MASK =
    MULTI_PROTECT ? wdc_pkg::CFG_MULTI_MASK : wdc_pkg::CFG_SINGLE_MASK;

  typedef enum logic [1:0] {
    PH_HOLD,
    PH_RUN,
    PH_SLEEP
  } wdc_phase_e;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wdc_phase_e phase;
    logic [31:0] drtCnt;
    logic [wdc_pkg::OPTION_W-1:0] option;
    logic [wdc_pkg::CFG_W-1:0] cfg;
    logic cfgLoaded;
    logic timeoutFlag_n;
    logic powerdownFlag_n;
    logic clrPulse;
    logic [wdc_pkg::IRQ_W-1:0] irqStatus;
    logic [wdc_pkg::IRQ_W-1:0] irqMask;
    logic irq;
    logic chipReset;
    logic coreRun;
  } wdc_state_s;

  wdc_state_s s_q;
  wdc_state_s s_d;

  logic expire;
  logic [wdc_pkg::COUNT_W-1:0] wdtCount;
  logic wdtEnabled;
  logic useWdtPost;
  logic apbAccess;
  logic apbWrite;
  logic apbRead;
  logic [wdc_pkg::IRQ_W-1:0] irqSet;
  logic [31:0] rdValue;
  logic rdError;
  logic cmdClear;
  logic cmdSleep;

  function automatic logic isReg(input logic [7:0] a, input logic [7:0] ofs);
    isReg = (a == ofs);
  endfunction

  // Fuse bit is only ever taken from the sampled word; no register
  // write reaches it, so software cannot stop a running watchdog.
  assign wdtEnabled = s_q.cfg[wdc_pkg::CFG_WDT_ENABLE];
  assign useWdtPost = s_q.option[wdc_pkg::OPT_PRESCALER_ASSIGN];

  // ----------------------------------------------------------------------
  // Watchdog counter
  // ----------------------------------------------------------------------
  wdc_wdt_counter #(
    .BASE_TICKS(WDT_BASE_TICKS),
    .CW(wdc_pkg::COUNT_W)
  ) u_counter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .oscTick(wdtOscTick),
    .enable(wdtEnabled && s_q.cfgLoaded),
    .clear(s_q.clrPulse || s_q.phase == PH_HOLD),
    .usePost(useWdtPost),
    .ratio(s_q.option[wdc_pkg::OPT_RATIO_LSB +: wdc_pkg::RATIO_W]),
    .expire_q(expire),
    .count_q(wdtCount)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign apbAccess = psel && penable && s_q.pready;
  assign apbWrite = apbAccess && pwrite;
  assign apbRead = psel && !penable && !pwrite;

  // Core instructions only act while the core is executing
  assign cmdClear = apbWrite && isReg(paddr, wdc_pkg::OFS_CMD) &&
    pwdata[wdc_pkg::CMD_WATCHDOG_CLEAR] && s_q.phase == PH_RUN;
  assign cmdSleep = apbWrite && isReg(paddr, wdc_pkg::OFS_CMD) &&
    pwdata[wdc_pkg::CMD_SLEEP] && s_q.phase == PH_RUN;

  always_comb begin
    rdValue = 32'h0000_0000;
    rdError = 1'b0;
    if (isReg(paddr, wdc_pkg::OFS_OPTION)) begin
      rdValue[wdc_pkg::OPTION_W-1:0] = s_q.option;
    end else if (isReg(paddr, wdc_pkg::OFS_CMD)) begin
      rdValue = 32'h0000_0000;
    end else if (isReg(paddr, wdc_pkg::OFS_STATUS)) begin
      rdValue[wdc_pkg::ST_RUNNING] = s_q.phase == PH_RUN;
      rdValue[wdc_pkg::ST_ASLEEP] = s_q.phase == PH_SLEEP;
      rdValue[wdc_pkg::ST_IN_RESET] = s_q.phase == PH_HOLD;
      rdValue[wdc_pkg::ST_POWERDOWN_N] = s_q.powerdownFlag_n;
      rdValue[wdc_pkg::ST_TIMEOUT_N] = s_q.timeoutFlag_n;
    end else if (isReg(paddr, wdc_pkg::OFS_CONFIG)) begin
      rdValue[wdc_pkg::CFG_W-1:0] = s_q.cfg;
    end else if (isReg(paddr, wdc_pkg::OFS_IRQ_STATUS)) begin
      rdValue[wdc_pkg::IRQ_W-1:0] = s_q.irqStatus;
    end else if (isReg(paddr, wdc_pkg::OFS_IRQ_MASK)) begin
      rdValue[wdc_pkg::IRQ_W-1:0] = s_q.irqMask;
    end else if (isReg(paddr, wdc_pkg::OFS_COUNT)) begin
      rdValue[wdc_pkg::COUNT_W-1:0] = wdtCount;
    end else begin
      rdError = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    irqSet = '0;
    s_d.clrPulse = 1'b0;

    // One wait-free access cycle: ready rises for the access phase
    s_d.pready = psel && !penable;
    s_d.pslverr = psel && !penable && rdError;
    if (apbRead) begin
      s_d.prdata = rdValue;
    end else if (psel && !penable) begin
      s_d.prdata = 32'h0000_0000;
    end

    // Configuration word is captured once, on the first cycle after
    // power-on reset, and is never written again while running.
    if (!s_q.cfgLoaded) begin
      s_d.cfg = configWordIn & CFG_MASK;
      s_d.cfgLoaded = 1'b1;
    end

    if (apbWrite) begin
      if (isReg(paddr, wdc_pkg::OFS_OPTION)) begin
        s_d.option = pwdata[wdc_pkg::OPTION_W-1:0];
      end
      if (isReg(paddr, wdc_pkg::OFS_IRQ_MASK)) begin
        s_d.irqMask = pwdata[wdc_pkg::IRQ_W-1:0];
      end
      if (isReg(paddr, wdc_pkg::OFS_IRQ_STATUS)) begin
        s_d.irqStatus = s_q.irqStatus & ~pwdata[wdc_pkg::IRQ_W-1:0];
      end
    end

    // Clear also resets the postscaler even with the watchdog fused off,
    // so a following move of the prescaler cannot fire a stale count.
    if (cmdClear) begin
      s_d.clrPulse = 1'b1;
      s_d.timeoutFlag_n = 1'b1;
      s_d.powerdownFlag_n = 1'b1;
    end
    if (cmdSleep) begin
      s_d.clrPulse = 1'b1;
      s_d.timeoutFlag_n = 1'b1;
      s_d.powerdownFlag_n = 1'b0;
      s_d.phase = PH_SLEEP;
    end

    unique case (s_q.phase)
      PH_HOLD: begin
        // Delay timer lets the crystal settle before the core runs
        if (s_q.drtCnt == DRT_LAST) begin
          s_d.phase = PH_RUN;
          s_d.drtCnt = 32'h0000_0000;
        end else begin
          s_d.drtCnt = s_q.drtCnt + 32'h0000_0001;
        end
      end
      PH_RUN: begin
      end
      PH_SLEEP: begin
        // No bus write leaves this phase; only the two resets below
      end
    endcase

    // Time-out acts in run and sleep alike, from inside the device
    if (expire && wdtEnabled && s_q.phase != PH_HOLD) begin
      s_d.phase = PH_HOLD;
      s_d.drtCnt = 32'h0000_0000;
      s_d.timeoutFlag_n = 1'b0;
      s_d.option = wdc_pkg::OPTION_RESET;
      s_d.clrPulse = 1'b0;
      irqSet[wdc_pkg::IRQ_TIMEOUT] = 1'b1;
      irqSet[wdc_pkg::IRQ_WAKE] = s_q.phase == PH_SLEEP;
    end

    // External reset holds the chip while the pin stays low
    if (!externalResetPin_n) begin
      irqSet[wdc_pkg::IRQ_WAKE] = s_q.phase == PH_SLEEP;
      s_d.phase = PH_HOLD;
      s_d.drtCnt = 32'h0000_0000;
      s_d.option = wdc_pkg::OPTION_RESET;
      s_d.clrPulse = 1'b0;
      if (s_q.phase != PH_SLEEP) begin
        s_d.timeoutFlag_n = s_q.timeoutFlag_n;
        s_d.powerdownFlag_n = s_q.powerdownFlag_n;
      end
    end

    // Hardware set wins over a same-cycle write-one clear
    s_d.irqStatus = s_d.irqStatus | irqSet;
    s_d.irq = |(s_d.irqStatus & s_d.irqMask);
    s_d.chipReset = s_d.phase == PH_HOLD;
    s_d.coreRun = s_d.phase == PH_RUN;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.prdata <= 32'h0000_0000;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.phase <= PH_HOLD;
      s_q.drtCnt <= 32'h0000_0000;
      s_q.option <= wdc_pkg::OPTION_RESET;
      s_q.cfg <= 12'h000;
      s_q.cfgLoaded <= 1'b0;
      s_q.timeoutFlag_n <= 1'b1;
      s_q.powerdownFlag_n <= 1'b1;
      s_q.clrPulse <= 1'b0;
      s_q.irqStatus <= 2'h0;
      s_q.irqMask <= 2'h0;
      s_q.irq <= 1'b0;
      s_q.chipReset <= 1'b1;
      s_q.coreRun <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign chipReset = s_q.chipReset;
  assign coreClockRun = s_q.coreRun;
  assign irq = s_q.irq;
  assign oscillatorSelect =
    s_q.cfg[wdc_pkg::CFG_OSC_LSB +: wdc_pkg::CFG_OSC_W];
  assign watchdogEnableFuse = s_q.cfg[wdc_pkg::CFG_WDT_ENABLE];
  assign codeProtect = s_q.cfg[wdc_pkg::CFG_W-1:wdc_pkg::CFG_PROTECT_LSB];
  assign prescalerToTimer0 = !s_q.option[wdc_pkg::OPT_PRESCALER_ASSIGN];

endmodule

// ==== wdc_watchdog_props.sv ====
// Port-level checker for the watchdog and configuration word block
`timescale 1ns/1ns
module wdc_watchdog_props #(
  parameter int RESET_DELAY_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdtOscTick,
  input wire logic externalResetPin_n,
  input wire logic [wdc_pkg::CFG_W-1:0] configWordIn,
  input wire logic chipReset,
  input wire logic coreClockRun,
  input wire logic [wdc_pkg::CFG_OSC_W-1:0] oscillatorSelect,
  input wire logic watchdogEnableFuse,
  input wire logic [8:0] codeProtect,
  input wire logic prescalerToTimer0,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Length of the current hold, restarted while the pin is low
  logic [31:0] holdCnt_q;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst || !externalResetPin_n || !chipReset) begin
      holdCnt_q <= 32'h0;
    end else begin
      holdCnt_q <= holdCnt_q + 32'h1;
    end
  end
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  a_fuse_off: assert property (
    !watchdogEnableFuse && externalResetPin_n && !chipReset |=> !chipReset)
    else $error("reset with watchdog fused off");
  a_pin_holds: assert property (!externalResetPin_n |=> chipReset)
    else $error("external reset not held");
  a_delay_len: assert property ($fell(chipReset) |->
    holdCnt_q >= RESET_DELAY_CYCLES - 1 && holdCnt_q <= RESET_DELAY_CYCLES + 2)
    else $error("reset hold length wrong");
  a_run_gate: assert property (coreClockRun |-> !chipReset)
    else $error("core runs during reset");
  a_reset_cause: assert property ($rose(chipReset) |->
    $past(externalResetPin_n) == 1'b0 || watchdogEnableFuse)
    else $error("reset without a cause");
  a_cfg_fields: assert property ($rose(coreClockRun) |->
    {codeProtect, watchdogEnableFuse, oscillatorSelect} == configWordIn)
    else $error("config outputs differ from word");
  a_cfg_frozen: assert property (coreClockRun |->
    $stable({codeProtect, watchdogEnableFuse, oscillatorSelect}))
    else $error("config outputs changed while running");
  a_option_map: assert property (
    psel && penable && pready && pwrite && paddr == wdc_pkg::OFS_OPTION
    |-> ##2 prescalerToTimer0 == !$past(pwdata[3], 2))
    else $error("prescaler assignment wrong");
  c_timeout: cover property ($rose(chipReset) && externalResetPin_n);
  c_sleep: cover property ($fell(coreClockRun) && !chipReset);
  c_unmapped: cover property (pslverr);
  c_irq: cover property ($rose(irq));
endmodule

bind wdc_watchdog wdc_watchdog_props #(
  .RESET_DELAY_CYCLES(RESET_DELAY_CYCLES)
) uProps (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .wdtOscTick, .externalResetPin_n,
  .configWordIn, .chipReset, .coreClockRun, .oscillatorSelect,
  .watchdogEnableFuse, .codeProtect, .prescalerToTimer0, .irq);

// ==== wdc_wdt_counter.sv ====
// Watchdog base counter with the shared postscaler stage
`timescale 1ns/1ns
module wdc_wdt_counter #(
  parameter int BASE_TICKS = wdc_pkg::WDT_BASE_TICKS,
  parameter int CW = wdc_pkg::COUNT_W
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic oscTick,
  input wire logic enable,
  input wire logic clear,
  input wire logic usePost,
  input wire logic [wdc_pkg::RATIO_W-1:0] ratio,
  output logic expire_q,
  output logic [CW-1:0] count_q
);

  localparam logic [CW-1:0] BASE_LAST = CW'(BASE_TICKS - 1);

  typedef struct packed {
    logic [CW-1:0] base;
    logic [6:0] post;
    logic expire;
  } wdc_cnt_s;

  wdc_cnt_s s_q;
  wdc_cnt_s s_d;
  logic [6:0] postLast;

  always_comb begin
    postLast = 7'((8'h01 << ratio) - 8'h01);
    s_d = s_q;
    s_d.expire = 1'b0;
    if (clear || !enable) begin
      // Counter and postscaler restart together
      s_d.base = '0;
      s_d.post = '0;
    end else if (oscTick) begin
      if (s_q.base == BASE_LAST) begin
        s_d.base = '0;
        if (!usePost || s_q.post == postLast) begin
          s_d.post = '0;
          s_d.expire = 1'b1;
        end else begin
          s_d.post = s_q.post + 7'h01;
        end
      end else begin
        s_d.base = s_q.base + CW'(1);
      end
    end
    if (!usePost) begin
      s_d.post = '0;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expire_q = s_q.expire;
  assign count_q = s_q.base;

endmodule
